// *** logic/uart_pkg.sv ***
// Contract
// R1: 8-bit mode frame: start, 8 data LSB-first, stop.
// R2: 8-bit mode: data to buffer, stop to ninth-flag.
// R3: Writing the data buffer starts transmission.
// R4: Transmit-done flag sets at stop bit start.
// R5: Receive only while receive enable is one.
// R6: 8-bit load needs flag clear, stop one if multiproc.
// R7: Failed load changes neither buffer, flag nor done.
// R8: Interrupt request when enabled and a flag set.
// R9: Selected timer overflow pulse clocks the baud logic.
// R10: Transmit and receive baud sources selected independently.
// R11: Timer 1 baud is overflow/32, or /16 doubled.
// R12: Timer 1 overflows at clock/(256 - reload).
// R13: Timers 2-4 baud is overflow/16 always.
// R14: Timers 2-4 overflow at clock/(65536 - reload).
// R15: 9-bit frame: start, 8 data, ninth, stop.
// R16: 9-bit mode: ninth bit to flag, stop discarded.
// R17: 9-bit load: flag clear and (no multiproc or address).
// R18: Fixed 9-bit mode baud is clock/64, or /32 doubled.
// R19: Variable 9-bit mode: 9-bit framing, timer baud.
// R20: Address bytes carry ninth bit one, data zero.
// R21: Address valid on masked or broadcast match.
// R22: Masked match compares only enabled address bits.
// R23: Broadcast address is address OR enable mask.
// R24: Start on falling edge, centre sampling at 16x.
package uart_pkg;
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_DATA = 3'h1;
  localparam logic [2:0] REG_STAT = 3'h2;
  localparam logic [2:0] REG_SADDR = 3'h3;
  localparam logic [2:0] REG_SADEN = 3'h4;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int CTRL_MP = 5;
  localparam int CTRL_REN = 4;
  localparam int CTRL_TB8 = 3;
  localparam int CTRL_RB8 = 2;
  localparam int CTRL_TI = 1;
  localparam int CTRL_RI = 0;
  localparam int STAT_DBL = 4;
  localparam logic [1:0] MODE_9B_FIX = 2'h2;
  localparam logic [1:0] SEL_TIMER1 = 2'h0;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] TICK_LAST = 4'(OVERSAMPLE - 1);
  localparam logic [3:0] HALF_LAST = 4'(OVERSAMPLE / 2 - 1);
  localparam int FIX_DIV_SLOW = 64;
  localparam int FIX_DIV_FAST = 32;
  localparam logic [1:0] FIX_SLOW_LAST = 2'(FIX_DIV_SLOW / OVERSAMPLE - 1);
  localparam logic [1:0] FIX_FAST_LAST = 2'(FIX_DIV_FAST / OVERSAMPLE - 1);
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;
endpackage

// *** logic/uart_link_if.sv ***
`timescale 1ns/1ps
interface uart_link_if;
  logic serial_tx_pin;
  logic serial_rx_pin;
  modport device_end (output serial_tx_pin, input serial_rx_pin);
  modport host_end (input serial_tx_pin, output serial_rx_pin);
endinterface

// *** logic/sync_fifo.sv ***
`timescale 1ns/1ps
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic [AW:0] count_nxt;
  logic room_r;
  wire push = in_valid_in && room_r;
  wire pop = out_ready_in && (count_r != '0);
  assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready_out = room_r;
  assign out_valid_out = (count_r != '0);
  assign out_data_out = mem[rd_ptr_r];
  // Pointers wrap by modulo, so depth must be a power of two.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      room_r <= 1'b1;
    end else begin
      wr_ptr_r <= wr_ptr_r + AW'(push);
      rd_ptr_r <= rd_ptr_r + AW'(pop);
      count_r <= count_nxt;
      room_r <= (count_nxt != (AW+1)'(DEPTH));
    end
  end
  always_ff @(posedge clock_in) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data_in;
    end
  end
endmodule // sync_fifo

// *** logic/uart_host.sv ***
`timescale 1ns/1ps
module uart_host (
  input wire logic clock_in,
  input wire logic rst_n_in,
  uart_link_if.host_end link,
  input wire logic [7:0] div_in,
  input wire logic nine_mode_in,
  input wire logic send_valid_in,
  input wire logic [8:0] send_data_in,
  output logic send_ready_out,
  output logic recv_valid_out,
  output logic [8:0] recv_data_out
);
  typedef enum logic {H_IDLE, H_BUSY} host_state_type;
  host_state_type tx_st_r;
  host_state_type rx_st_r;
  logic [7:0] div_cnt_r;
  logic [3:0] tx_cnt_r;
  logic [3:0] rx_cnt_r;
  logic [3:0] tx_left_r;
  logic [3:0] rx_bits_r;
  logic [10:0] tx_frame_r;
  logic [10:0] rx_sh_r;
  logic rx_prev_r;
  // A divisor lowered below the running count would otherwise wrap through all 256 states first.
  wire tick = (div_cnt_r >= div_in);
  wire tx_end = tick && (tx_cnt_r == uart_pkg::TICK_LAST);
  wire rx_end = tick && (rx_cnt_r == uart_pkg::TICK_LAST);
  wire [3:0] frame_bits = nine_mode_in ? 4'hB : 4'hA;
  wire [10:0] rx_sh_nxt = {link.serial_tx_pin, rx_sh_r[10:1]};
  wire rx_last = (rx_bits_r == frame_bits - 4'h1);
  // Address bytes carry the ninth bit set; the caller supplies it in bit 8. [R20]
  wire [10:0] frame_load = nine_mode_in ? {1'b1, send_data_in, 1'b0} : {2'b11, send_data_in[7:0], 1'b0}; // [R1] [R15]
  assign link.serial_rx_pin = tx_frame_r[0];
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_cnt_r <= 8'h00;
      tx_st_r <= H_IDLE;
      tx_cnt_r <= 4'h0;
      tx_left_r <= 4'h0;
      tx_frame_r <= 11'h7FF;
      send_ready_out <= 1'b1;
    end else begin
      div_cnt_r <= tick ? 8'h00 : div_cnt_r + 8'h01;
      case (tx_st_r)
        H_IDLE: if (send_valid_in) begin
          tx_frame_r <= frame_load;
          tx_left_r <= frame_bits;
          tx_cnt_r <= 4'h0;
          tx_st_r <= H_BUSY;
          send_ready_out <= 1'b0;
        end
        H_BUSY: if (tick) begin
          tx_cnt_r <= tx_cnt_r + 4'h1;
          if (tx_end) begin
            tx_frame_r <= {1'b1, tx_frame_r[10:1]};
            tx_left_r <= tx_left_r - 4'h1;
            if (tx_left_r == 4'h1) begin
              tx_st_r <= H_IDLE;
              send_ready_out <= 1'b1;
            end
          end
        end
        default: tx_st_r <= H_IDLE;
      endcase
    end
  end
  // Entering at count eight puts every later sample near a bit centre.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_st_r <= H_IDLE;
      rx_prev_r <= 1'b1;
      rx_cnt_r <= 4'h0;
      rx_bits_r <= 4'h0;
      rx_sh_r <= 11'h000;
      recv_valid_out <= 1'b0;
      recv_data_out <= 9'h000;
    end else begin
      rx_prev_r <= link.serial_tx_pin;
      recv_valid_out <= 1'b0;
      case (rx_st_r)
        H_IDLE: if (rx_prev_r && !link.serial_tx_pin) begin
          rx_st_r <= H_BUSY;
          rx_cnt_r <= 4'h8;
          rx_bits_r <= 4'h0;
        end
        H_BUSY: if (tick) begin
          rx_cnt_r <= rx_cnt_r + 4'h1;
          if (rx_end) begin
            rx_sh_r <= rx_sh_nxt;
            rx_bits_r <= rx_bits_r + 4'h1;
            if (rx_last) begin
              rx_st_r <= H_IDLE;
              recv_valid_out <= 1'b1;
              recv_data_out <= nine_mode_in ? rx_sh_nxt[9:1] : rx_sh_nxt[10:2];
            end
          end
        end
        default: rx_st_r <= H_IDLE;
      endcase
    end
  end
endmodule // uart_host

// *** logic/uart_device.sv ***
`timescale 1ns/1ps
module uart_device (
  input wire logic clock_in,
  input wire logic rst_n_in,
  uart_link_if.device_end link,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [2:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic [3:0] timer_ovf_in,
  input wire logic irq_enable_in,
  output logic [7:0] sfr_rdata_out,
  output logic tx_space_out,
  output logic irq_out
);
  typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_NINTH, S_STOP} bit_state_type;
  logic [7:0] ctrl_r;
  logic [7:0] stat_r;
  logic [7:0] saddr_r;
  logic [7:0] saden_r;
  logic [7:0] rxbuf_r;
  logic rb8_r;
  logic ti_r;
  logic ri_r;
  logic ti_nxt;
  logic ri_nxt;
  logic [1:0] fix_cnt_r;
  logic [1:0] half_r;
  logic [1:0] tick;
  bit_state_type tx_st_r;
  bit_state_type tx_st_nxt;
  logic [3:0] tx_cnt_r;
  logic [2:0] tx_bit_r;
  logic [2:0] tx_bit_nxt;
  logic [7:0] tx_sh_r;
  logic [7:0] tx_sh_nxt;
  logic tx_nb_r;
  logic tx_pin_r;
  logic tx_pin_nxt;
  logic tx_stop_ev;
  bit_state_type rx_st_r;
  bit_state_type rx_st_nxt;
  logic [3:0] rx_cnt_r;
  logic [3:0] rx_cnt_nxt;
  logic [2:0] rx_bit_r;
  logic [2:0] rx_bit_nxt;
  logic [7:0] rx_sh_r;
  logic [7:0] rx_sh_nxt;
  logic rx_nb_r;
  logic rx_nb_nxt;
  logic rx_prev_r;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic fifo_room;
  wire [1:0] mode = ctrl_r[7:6];
  wire nine_mode = mode[1];
  wire fixed_mode = (mode == uart_pkg::MODE_9B_FIX);
  wire dbl = stat_r[uart_pkg::STAT_DBL];
  wire mp_en = ctrl_r[uart_pkg::CTRL_MP];
  wire wr_ctrl = sfr_wr_in && (sfr_addr_in == uart_pkg::REG_CTRL);
  wire wr_data = sfr_wr_in && (sfr_addr_in == uart_pkg::REG_DATA);
  wire wr_stat = sfr_wr_in && (sfr_addr_in == uart_pkg::REG_STAT);
  wire wr_saddr = sfr_wr_in && (sfr_addr_in == uart_pkg::REG_SADDR);
  wire wr_saden = sfr_wr_in && (sfr_addr_in == uart_pkg::REG_SADEN);
  wire [7:0] ctrl_view = {ctrl_r[7:3], rb8_r, ti_r, ri_r};
  wire [7:0] rd_mux = (sfr_addr_in == uart_pkg::REG_CTRL) ? ctrl_view :
                      (sfr_addr_in == uart_pkg::REG_DATA) ? rxbuf_r :
                      (sfr_addr_in == uart_pkg::REG_STAT) ? stat_r :
                      (sfr_addr_in == uart_pkg::REG_SADDR) ? saddr_r :
                      (sfr_addr_in == uart_pkg::REG_SADEN) ? saden_r : 8'h00;

  // Fixed mode: 16x tick every 4 clocks, or every 2 when doubled. [R18]
  wire fix_tick = (fix_cnt_r == (dbl ? uart_pkg::FIX_FAST_LAST : uart_pkg::FIX_SLOW_LAST));

  // Index 0 is the transmit baud source, index 1 the receive one. [R10]
  for (genvar d = 0; d < 2; d++) begin : g_baud
    wire [1:0] sel = d == 0 ? stat_r[3:2] : stat_r[1:0];
    wire ovf = timer_ovf_in[sel]; // [R9]
    wire t1 = (sel == uart_pkg::SEL_TIMER1);
    // Timer 1 halves the overflow rate unless doubled; the others pass every overflow. [R11] [R13] [R19]
    assign tick[d] = fixed_mode ? fix_tick : (ovf && (!t1 || dbl || half_r[d]));
    always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        half_r[d] <= 1'b0;
      end else if (ovf && t1) begin
        half_r[d] <= !half_r[d];
      end
    end
  end

  // Writes while the queue is full are dropped; tx_space_out warns software. [R3]
  sync_fifo #(.WIDTH(uart_pkg::DATA_W), .DEPTH(uart_pkg::FIFO_DEPTH)) u_tx_fifo (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(wr_data),
    .in_ready_out(fifo_room),
    .in_data_in(sfr_wdata_in),
    .out_valid_out(fifo_valid),
    .out_ready_in(tx_st_r == S_IDLE),
    .out_data_out(fifo_data)
  );

  wire tx_end = tick[0] && (tx_cnt_r == uart_pkg::TICK_LAST);
  always_comb begin
    tx_st_nxt = tx_st_r;
    tx_bit_nxt = tx_bit_r;
    tx_sh_nxt = tx_sh_r;
    tx_pin_nxt = tx_pin_r;
    tx_stop_ev = 1'b0;
    case (tx_st_r)
      S_IDLE: if (fifo_valid) begin
        tx_st_nxt = S_START;
        tx_sh_nxt = fifo_data;
        tx_pin_nxt = 1'b0; // [R1] [R15]
      end
      S_START: if (tx_end) begin
        tx_st_nxt = S_DATA;
        tx_bit_nxt = 3'h0;
        tx_pin_nxt = tx_sh_r[0];
      end
      S_DATA: if (tx_end) begin
        tx_sh_nxt = {1'b0, tx_sh_r[7:1]};
        tx_bit_nxt = tx_bit_r + 3'h1;
        tx_pin_nxt = tx_sh_r[1];
        if (tx_bit_r == uart_pkg::LAST_DATA_BIT) begin
          tx_st_nxt = nine_mode ? S_NINTH : S_STOP;
          tx_pin_nxt = nine_mode ? tx_nb_r : 1'b1; // [R15]
          tx_stop_ev = !nine_mode; // [R4]
        end
      end
      S_NINTH: if (tx_end) begin
        tx_st_nxt = S_STOP;
        tx_pin_nxt = 1'b1;
        tx_stop_ev = 1'b1; // [R4]
      end
      S_STOP: if (tx_end) begin
        tx_st_nxt = S_IDLE;
      end
      default: tx_st_nxt = S_IDLE;
    endcase
  end

  wire rx_pin = link.serial_rx_pin;
  wire rx_end = tick[1] && (rx_cnt_r == uart_pkg::TICK_LAST);
  wire rx_half = tick[1] && (rx_cnt_r == uart_pkg::HALF_LAST);
  wire [7:0] bcast = saddr_r | saden_r; // [R23]
  wire mask_hit = (((rx_sh_r ^ saddr_r) & saden_r) == 8'h00); // [R22]
  wire bcast_hit = ((rx_sh_r & bcast) == bcast); // [R23]
  wire addr_ok = mask_hit || bcast_hit; // [R21]
  // With multiprocessor mode on, eight-bit mode needs the stop bit, nine-bit mode an address byte that matches. [R6] [R17] [R20]
  wire load_ok = !ri_r && (!mp_en || (nine_mode ? (rx_nb_r && addr_ok) : rx_pin));
  wire rx_load = (rx_st_r == S_STOP) && rx_end && load_ok; // [R7]
  always_comb begin
    rx_st_nxt = rx_st_r;
    rx_cnt_nxt = tick[1] ? rx_cnt_r + 4'h1 : rx_cnt_r;
    rx_bit_nxt = rx_bit_r;
    rx_sh_nxt = rx_sh_r;
    rx_nb_nxt = rx_nb_r;
    case (rx_st_r)
      S_IDLE: begin
        rx_cnt_nxt = 4'h0;
        if (ctrl_r[uart_pkg::CTRL_REN] && rx_prev_r && !rx_pin) begin
          rx_st_nxt = S_START; // [R5] [R24]
        end
      end
      S_START: if (rx_half) begin
        // A start bit gone high by mid-bit is a glitch and is dropped.
        rx_st_nxt = rx_pin ? S_IDLE : S_DATA; // [R24]
        rx_cnt_nxt = 4'h0;
        rx_bit_nxt = 3'h0;
      end
      S_DATA: if (rx_end) begin
        rx_sh_nxt = {rx_pin, rx_sh_r[7:1]};
        rx_bit_nxt = rx_bit_r + 3'h1;
        if (rx_bit_r == uart_pkg::LAST_DATA_BIT) begin
          rx_st_nxt = nine_mode ? S_NINTH : S_STOP;
        end
      end
      S_NINTH: if (rx_end) begin
        rx_nb_nxt = rx_pin;
        rx_st_nxt = S_STOP;
      end
      S_STOP: if (rx_end) begin
        rx_st_nxt = S_IDLE;
      end
      default: rx_st_nxt = S_IDLE;
    endcase
  end

  // Hardware set wins over a software clear in the same cycle.
  assign ti_nxt = tx_stop_ev ? 1'b1 : (wr_ctrl ? sfr_wdata_in[uart_pkg::CTRL_TI] : ti_r);
  assign ri_nxt = rx_load ? 1'b1 : (wr_ctrl ? sfr_wdata_in[uart_pkg::CTRL_RI] : ri_r);

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_r <= uart_pkg::REG_RESET;
      stat_r <= uart_pkg::REG_RESET; // [R11]
      saddr_r <= uart_pkg::REG_RESET;
      saden_r <= uart_pkg::REG_RESET;
      fix_cnt_r <= 2'h0;
      ti_r <= 1'b0;
      ri_r <= 1'b0;
      sfr_rdata_out <= 8'h00;
      tx_space_out <= 1'b1;
      irq_out <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_r <= {sfr_wdata_in[7:3], 3'b000};
      if (wr_stat) stat_r <= {3'b000, sfr_wdata_in[4:0]};
      if (wr_saddr) saddr_r <= sfr_wdata_in;
      if (wr_saden) saden_r <= sfr_wdata_in;
      fix_cnt_r <= fix_tick ? 2'h0 : fix_cnt_r + 2'h1;
      ti_r <= ti_nxt;
      ri_r <= ri_nxt;
      if (sfr_rd_in) sfr_rdata_out <= rd_mux;
      tx_space_out <= fifo_room;
      irq_out <= irq_enable_in && (ti_nxt || ri_nxt); // [R8]
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_st_r <= S_IDLE;
      tx_cnt_r <= 4'h0;
      tx_bit_r <= 3'h0;
      tx_sh_r <= 8'h00;
      tx_nb_r <= 1'b0;
      tx_pin_r <= 1'b1;
    end else begin
      tx_st_r <= tx_st_nxt;
      tx_cnt_r <= (tx_st_r == S_IDLE) ? 4'h0 : tx_cnt_r + 4'(tick[0]);
      tx_bit_r <= tx_bit_nxt;
      tx_sh_r <= tx_sh_nxt;
      if (tx_st_r == S_IDLE) tx_nb_r <= ctrl_r[uart_pkg::CTRL_TB8]; // [R15]
      tx_pin_r <= tx_pin_nxt;
    end
  end
  assign link.serial_tx_pin = tx_pin_r;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_st_r <= S_IDLE;
      rx_cnt_r <= 4'h0;
      rx_bit_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_nb_r <= 1'b0;
      rx_prev_r <= 1'b1;
      rxbuf_r <= 8'h00;
      rb8_r <= 1'b0;
    end else begin
      rx_st_r <= rx_st_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_bit_r <= rx_bit_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_nb_r <= rx_nb_nxt;
      rx_prev_r <= rx_pin;
      if (rx_load) begin
        rxbuf_r <= rx_sh_r; // [R2]
        rb8_r <= nine_mode ? rx_nb_r : rx_pin; // [R2] [R16]
      end
    end
  end
endmodule // uart_device

// *** testbench/uart_link_props.sv ***
`timescale 1ns/1ps
module uart_link_props (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic serial_tx_pin,
  input wire logic serial_rx_pin,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [2:0] sfr_addr_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic irq_enable_in,
  input wire logic irq_out,
  input wire logic tx_space_out,
  input wire logic send_valid_in,
  input wire logic send_ready_out,
  input wire logic recv_valid_out,
  input wire logic [8:0] recv_data_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  // A bit is 16 ticks of two clocks or more, so no line level may last under eight clocks.
  a_tx_low_len: assert property ($fell(serial_tx_pin) |-> !serial_tx_pin [*8]) else $error("short low on tx");
  a_tx_high_len: assert property ($rose(serial_tx_pin) |-> serial_tx_pin [*8]) else $error("short high on tx");
  a_rx_low_len: assert property ($fell(serial_rx_pin) |-> !serial_rx_pin [*8]) else $error("short low on rx");
  a_irq_gate_off: assert property (!irq_enable_in |=> !irq_out) else $error("irq while disabled");
  // Flags are only cleared by software, so a raised request must stay until a control write.
  a_irq_holds_up: assert property (irq_out && irq_enable_in && !(sfr_wr_in && sfr_addr_in == uart_pkg::REG_CTRL)
    |=> irq_out) else $error("irq dropped");
  a_recv_one_pulse: assert property (recv_valid_out |=> !recv_valid_out) else $error("long recv pulse");
  a_recv_data_hold: assert property (!recv_valid_out |-> $stable(recv_data_out)) else $error("recv data moved");
  a_host_busy_frame: assert property ($fell(serial_rx_pin) |-> !send_ready_out) else $error("ready in frame");
  a_ready_stays_up: assert property (send_ready_out && !send_valid_in |=> send_ready_out) else $error("ready lost");
  a_rdata_hold: assert property (!sfr_rd_in |=> $stable(sfr_rdata_out)) else $error("read data moved");
  c_addr_recv: cover property (recv_valid_out && recv_data_out[8]);
  c_irq_up: cover property ($rose(irq_out));
  c_fifo_full: cover property ($fell(tx_space_out));
endmodule // uart_link_props

// *** testbench/test_async_uart_multiproc_modes.sv ***
`timescale 1ns/1ps
module test_async_uart_multiproc_modes;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic sfr_wr_in, sfr_rd_in, irq_enable_in, tx_space_out, irq_out, nine_mode_in;
  logic send_valid_in, send_ready_out, recv_valid_out;
  logic [2:0] sfr_addr_in;
  logic [7:0] sfr_wdata_in, sfr_rdata_out, div_in, rv;
  logic [3:0] timer_ovf_in = 4'h0;
  logic [8:0] send_data_in, recv_data_out;
  logic [8:0] mp_word [6] = '{9'h1F5, 9'h0F5, 9'h1F6, 9'h1FF, 9'h13F, 9'h105};
  logic mp_hit [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  int miscompares = 0;
  int n_checks = 0;
  int cnt = 0;
  int k;
  int per [4] = '{0, 0, 0, 0};
  uart_link_if uart_link_if_inst ();
  uart_device uart_device_inst (.clock_in(clock_in), .rst_n_in(rst_n_in), .link(uart_link_if_inst),
    .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in),
    .timer_ovf_in(timer_ovf_in), .irq_enable_in(irq_enable_in), .sfr_rdata_out(sfr_rdata_out),
    .tx_space_out(tx_space_out), .irq_out(irq_out));
  uart_host uart_host_inst (.clock_in(clock_in), .rst_n_in(rst_n_in), .link(uart_link_if_inst), .div_in(div_in),
    .nine_mode_in(nine_mode_in), .send_valid_in(send_valid_in), .send_data_in(send_data_in),
    .send_ready_out(send_ready_out), .recv_valid_out(recv_valid_out), .recv_data_out(recv_data_out));
  uart_link_props uart_link_props_inst (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .serial_tx_pin(uart_link_if_inst.serial_tx_pin), .serial_rx_pin(uart_link_if_inst.serial_rx_pin),
    .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_addr_in(sfr_addr_in), .sfr_rdata_out(sfr_rdata_out),
    .irq_enable_in(irq_enable_in), .irq_out(irq_out), .tx_space_out(tx_space_out), .send_valid_in(send_valid_in),
    .send_ready_out(send_ready_out), .recv_valid_out(recv_valid_out), .recv_data_out(recv_data_out));
  always #20 clock_in = ~clock_in;
  // Timers 1 and 4 overflow at their own periods and timers 2 and 3 share one, so selecting timer 1 or 4 shows as a garbled byte.
  // A period stands for 256, or 65536, minus the reload value of that timer.
  always @(negedge clock_in) begin
    cnt <= cnt + 1;
    for (int i = 0; i < 4; i++) begin
      timer_ovf_in[i] <= per[i] != 0 && cnt % per[i] == 0;
    end
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clock_in);
    sfr_wr_in = 1'b1;
    sfr_addr_in = a;
    sfr_wdata_in = d;
    @(negedge clock_in);
    sfr_wr_in = 1'b0;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
    @(negedge clock_in);
    sfr_rd_in = 1'b1;
    sfr_addr_in = a;
    @(negedge clock_in);
    sfr_rd_in = 1'b0;
    chk({1'b0, sfr_rdata_out}, {1'b0, exp});
  endtask
  function automatic logic [7:0] ctrl(input logic [1:0] m, input logic mp, input logic ren, input logic tb8);
    return {m, mp, ren, tb8, 3'h0};
  endfunction
  task automatic hsend(input logic [8:0] d);
    int n;
    @(negedge clock_in);
    for (n = 0; n < 3000 && send_ready_out !== 1'b1; n++) @(negedge clock_in);
    send_valid_in = 1'b1;
    send_data_in = d;
    @(negedge clock_in);
    send_valid_in = 1'b0;
    for (n = 0; n < 3000 && send_ready_out !== 1'b1; n++) @(negedge clock_in);
    if (send_ready_out !== 1'b1) begin
      miscompares++;
      $display("Error at %0t: host sender never became ready", $time);
    end
  endtask
  task automatic hrecv(input logic [8:0] exp);
    int n;
    n = 0;
    do begin
      @(posedge clock_in);
      #1;
      n++;
    end while (recv_valid_out !== 1'b1 && n < 3000);
    if (recv_valid_out !== 1'b1) begin
      miscompares++;
      $display("Error at %0t: no frame reached the host", $time);
    end
    chk(recv_data_out, exp);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clock_in);
    miscompares++;
    $display("Error at %0t: watchdog expired", $time);
    conclude();
  end
  initial begin
    sfr_wr_in = 1'b0;
    sfr_rd_in = 1'b0;
    sfr_addr_in = 3'h0;
    sfr_wdata_in = 8'h00;
    irq_enable_in = 1'b1;
    div_in = 8'h03;
    nine_mode_in = 1'b1;
    send_valid_in = 1'b0;
    send_data_in = 9'h000;
    repeat (3) @(negedge clock_in);
    rst_n_in = 1'b1;
    for (int a = 0; a < 8; a++) rdc(3'(a), 8'h00);
    chk(irq_out, 1'b0);
    $display("test reset done");
    wr(uart_pkg::REG_CTRL, ctrl(2'h2, 1'b0, 1'b0, 1'b1));
    wr(uart_pkg::REG_DATA, 8'hA5);
    rdc(uart_pkg::REG_CTRL, ctrl(2'h2, 1'b0, 1'b0, 1'b1));
    hrecv(9'h1A5);
    rdc(uart_pkg::REG_CTRL, ctrl(2'h2, 1'b0, 1'b0, 1'b1) | 8'h02);
    chk(irq_out, 1'b1);
    irq_enable_in = 1'b0;
    repeat (2) @(negedge clock_in);
    chk(irq_out, 1'b0);
    irq_enable_in = 1'b1;
    wr(uart_pkg::REG_CTRL, ctrl(2'h2, 1'b0, 1'b0, 1'b0));
    @(negedge clock_in);
    chk(irq_out, 1'b0);
    $display("test transmit done");
    hsend(9'h03C);
    rdc(uart_pkg::REG_CTRL, ctrl(2'h2, 1'b0, 1'b0, 1'b0));
    wr(uart_pkg::REG_CTRL, ctrl(2'h2, 1'b0, 1'b1, 1'b0));
    hsend(9'h15A);
    hsend(9'h011);
    rdc(uart_pkg::REG_DATA, 8'h5A);
    rdc(uart_pkg::REG_CTRL, ctrl(2'h2, 1'b0, 1'b1, 1'b0) | 8'h05);
    $display("test receive done");
    wr(uart_pkg::REG_SADDR, 8'h35);
    wr(uart_pkg::REG_SADEN, 8'h0F);
    wr(uart_pkg::REG_CTRL, ctrl(2'h2, 1'b1, 1'b1, 1'b0));
    for (int i = 0; i < 6; i++) begin
      hsend(mp_word[i]);
      rdc(uart_pkg::REG_CTRL, ctrl(2'h2, 1'b1, 1'b1, 1'b0) | 8'h04 | 8'(mp_hit[i]));
      if (mp_hit[i]) begin
        rdc(uart_pkg::REG_DATA, mp_word[i][7:0]);
        wr(uart_pkg::REG_CTRL, ctrl(2'h2, 1'b1, 1'b1, 1'b0));
      end
    end
    $display("test address done");
    wr(uart_pkg::REG_STAT, 8'h10);
    div_in = 8'h01;
    wr(uart_pkg::REG_CTRL, ctrl(2'h2, 1'b0, 1'b1, 1'b0));
    wr(uart_pkg::REG_DATA, 8'h3C);
    hrecv(9'h03C);
    hsend(9'h1C7);
    rdc(uart_pkg::REG_DATA, 8'hC7);
    $display("test fast mode done");
    div_in = 8'h03;
    nine_mode_in = 1'b0;
    for (int d = 0; d < 2; d++) begin
      per[0] = d ? 4 : 2;
      wr(uart_pkg::REG_STAT, d ? 8'h10 : 8'h00);
      wr(uart_pkg::REG_CTRL, ctrl(2'h1, 1'b1, 1'b1, 1'b0));
      wr(uart_pkg::REG_DATA, 8'h96);
      hrecv(9'h196);
      hsend(9'h1C3);
      rdc(uart_pkg::REG_CTRL, ctrl(2'h1, 1'b1, 1'b1, 1'b0) | 8'h07);
      rdc(uart_pkg::REG_DATA, 8'hC3);
    end
    $display("test timer one done");
    per = '{3, 4, 4, 5};
    nine_mode_in = 1'b1;
    wr(uart_pkg::REG_STAT, 8'h16);
    wr(uart_pkg::REG_CTRL, ctrl(2'h3, 1'b0, 1'b1, 1'b1));
    wr(uart_pkg::REG_DATA, 8'h69);
    hrecv(9'h169);
    hsend(9'h096);
    rdc(uart_pkg::REG_DATA, 8'h96);
    $display("test timer select done");
    wr(uart_pkg::REG_STAT, 8'h00);
    wr(uart_pkg::REG_CTRL, ctrl(2'h2, 1'b0, 1'b0, 1'b0));
    for (k = 0; k < 12 && tx_space_out === 1'b1; k++) begin
      wr(uart_pkg::REG_DATA, 8'(8'h40 + k));
      @(negedge clock_in);
    end
    chk(tx_space_out, 1'b0);
    chk(k >= 8, 1'b1);
    for (int j = 0; j < k; j++) hrecv({1'b0, 8'(8'h40 + j)});
    $display("test queue done");
    conclude();
  end
endmodule // test_async_uart_multiproc_modes
